// ---- hw/flash_reset_pkg.sv ----
// constants for the host-side reset sequencer of a parallel nor flash
// assumes a 20 mhz system clock; times are held in their printed units
//
// What this block does
// - host waits 300 us of valid supplies before first access
// - reset during power-up: pulse 200 ns, recovery 35 us, counted from supply end
// - reset high at least 50 ns before chip select falls
// - pulse width plus reset-high-to-select not shorter than recovery time
// - chip select high at least 20 ns whenever deasserted in sequence
package flash_reset_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	// printed times
	localparam int CORE_SUPPLY_SETUP_TIME_US = 300;
	localparam int IO_SUPPLY_SETUP_TIME_US = 300;
	localparam int RESET_RECOVERY_TIME_US = 35;
	localparam int RESET_PULSE_WIDTH_NS = 200;
	localparam int RESET_HIGH_TO_SELECT_TIME_NS = 50;
	localparam int SELECT_HIGH_PULSE_WIDTH_NS = 20;
	// cycle counts, rounded up, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int SUPPLY_SETUP_US = (CORE_SUPPLY_SETUP_TIME_US > IO_SUPPLY_SETUP_TIME_US) ?
		CORE_SUPPLY_SETUP_TIME_US : IO_SUPPLY_SETUP_TIME_US;
	localparam int SUPPLY_SETUP_CYC = ns_to_cyc(SUPPLY_SETUP_US * 1000);
	localparam int RECOVERY_CYC = ns_to_cyc(RESET_RECOVERY_TIME_US * 1000);
	localparam int PULSE_CYC = ns_to_cyc(RESET_PULSE_WIDTH_NS);
	localparam int HIGH_TO_SELECT_CYC = ns_to_cyc(RESET_HIGH_TO_SELECT_TIME_NS);
	localparam int SELECT_HIGH_CYC = ns_to_cyc(SELECT_HIGH_PULSE_WIDTH_NS);
	localparam int CNT_W = 16;

	typedef enum logic [2:0] {
		ST_SUPPLY = 3'h0,
		ST_PULSE = 3'h1,
		ST_RECOVER = 3'h2,
		ST_HIGH_WAIT = 3'h3,
		ST_BUSY_WAIT = 3'h4,
		ST_READY = 3'h5
	} seq_state_t;
endpackage

// ---- hw/flash_reset_host.sv ----
// host controller that sequences reset of a parallel nor flash
// assumes supplies valid is a pin-level input asserted once both rails are at minimum
`timescale 1ns/1ns
module flash_reset_host
	import flash_reset_pkg::*;
#(
	parameter int SUPPLY_CYC = SUPPLY_SETUP_CYC,
	parameter int RECOVER_CYC = RECOVERY_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// user side
	input wire logic supply_ok,
	input wire logic warm_req,
	input wire logic hold_select,
	output logic flash_ready,
	output logic seq_busy,
	// flash pins
	output logic reset_n,
	output logic select_n,
	input wire logic ready_busy_n
);
	initial begin
		if (SUPPLY_CYC < 1 || SUPPLY_CYC >= (1 << CNT_W) || RECOVER_CYC < 1 ||
				RECOVER_CYC >= (1 << CNT_W) || PULSE_CYC + HIGH_TO_SELECT_CYC < 1)
			$error("flash_reset_host: counts out of range");
	end

	// ==========================================================
	// pin synchronisers
	logic [1:0] sup_sync;
	logic [1:0] rb_sync;
	logic sup_s;
	logic rb_s;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sup_sync <= 2'h0;
			rb_sync <= 2'h0;
		end else begin
			sup_sync <= {sup_sync[0], supply_ok};
			rb_sync <= {rb_sync[0], ready_busy_n};
		end
	end
	assign sup_s = sup_sync[1];
	assign rb_s = rb_sync[1];

	// ==========================================================
	// sequencer
	seq_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [CNT_W-1:0] rec_cnt, next_rec_cnt;
	logic rst_pin, next_rst_pin;
	logic sel_pin, next_sel_pin;
	logic [CNT_W-1:0] sel_hi, next_sel_hi;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_rec_cnt = (rec_cnt != '0) ? rec_cnt - 1'b1 : rec_cnt;
		next_rst_pin = rst_pin;
		next_sel_pin = 1'b1;
		next_sel_hi = (sel_pin && sel_hi != '0) ? sel_hi - 1'b1 : sel_hi;
		unique case (state)
			ST_SUPPLY: begin
				// reset held low through power-up; device ignores it anyway
				next_rst_pin = 1'b0;
				if (!sup_s) begin
					next_cnt = CNT_W'(SUPPLY_CYC);
				end else if (cnt != '0) begin
					next_cnt = cnt - 1'b1;
				end else begin
					// pulse started at power-up; recovery counts from supply end
					next_state = ST_RECOVER;
					next_rec_cnt = CNT_W'(RECOVER_CYC);
				end
			end
			ST_PULSE: begin
				next_rst_pin = 1'b0;
				if (cnt != '0) begin
					next_cnt = cnt - 1'b1;
				end else begin
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				// pulse plus high-to-select must cover recovery
				next_rst_pin = 1'b0;
				if (rec_cnt <= CNT_W'(HIGH_TO_SELECT_CYC)) begin
					next_state = ST_HIGH_WAIT;
					next_rst_pin = 1'b1;
					next_cnt = CNT_W'(HIGH_TO_SELECT_CYC);
				end
			end
			ST_HIGH_WAIT: begin
				next_rst_pin = 1'b1;
				if (cnt > 1) begin
					next_cnt = cnt - 1'b1;
				end else begin
					next_state = ST_BUSY_WAIT;
				end
			end
			ST_BUSY_WAIT: begin
				// device reports busy during its own reset
				if (rb_s && rec_cnt == '0) begin
					next_state = ST_READY;
				end
			end
			ST_READY: begin
				// select falling is the first read; held low it reads at once
				next_sel_pin = !(hold_select && sel_hi == '0);
				if (warm_req) begin
					next_state = ST_PULSE;
					next_rst_pin = 1'b0;
					next_sel_pin = 1'b1;
					next_cnt = CNT_W'(PULSE_CYC - 1);
					next_rec_cnt = CNT_W'(RECOVER_CYC);
				end
			end
			default: begin
				next_state = ST_SUPPLY;
				next_cnt = CNT_W'(SUPPLY_CYC);
			end
		endcase
		if (next_sel_pin && !sel_pin) begin
			next_sel_hi = CNT_W'(SELECT_HIGH_CYC);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_SUPPLY;
			cnt <= CNT_W'(SUPPLY_CYC);
			rec_cnt <= '0;
			rst_pin <= 1'b0;
			sel_pin <= 1'b1;
			sel_hi <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rec_cnt <= next_rec_cnt;
			rst_pin <= next_rst_pin;
			sel_pin <= next_sel_pin;
			sel_hi <= next_sel_hi;
		end
	end

	assign reset_n = rst_pin;
	assign select_n = sel_pin;
	assign flash_ready = (state == ST_READY);
	assign seq_busy = (state != ST_READY);
endmodule // flash_reset_host

// ---- dv/flash_reset_host_asserts.sv ----
// port checks for the reset sequencer
// assumes it is bound onto every host instance
`timescale 1ns/1ns
module flash_reset_host_asserts #(parameter int SUPPLY_CYC = 20, parameter int RECOVER_CYC = 10) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// user side
	input wire logic supply_ok,
	input wire logic warm_req,
	input wire logic hold_select,
	input wire logic flash_ready,
	input wire logic seq_busy,
	// flash pins
	input wire logic reset_n,
	input wire logic select_n,
	input wire logic ready_busy_n
);
	int ok_cnt;
	// raw supply count; the host's sync delay only adds margin
	always_ff @(posedge clk) ok_cnt <= supply_ok ? ok_cnt + 1 : 0;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ====
	// checks
	sel_in_reset_a: assert property (!reset_n |-> select_n) else $error("select low in reset");
	reset_lead_a: assert property ($fell(select_n) |-> reset_n && $past(reset_n))
		else $error("select fell too soon");
	pulse_min_a: assert property ($fell(reset_n) |-> !reset_n [*4]) else $error("pulse short");
	recovery_a: assert property ($rose(reset_n) |-> !$past(reset_n, RECOVER_CYC - 1))
		else $error("recovery short");
	supply_wait_a: assert property ($rose(reset_n) |-> ok_cnt >= SUPPLY_CYC + RECOVER_CYC - 1)
		else $error("supply setup short");
	warm_go_a: assert property (flash_ready && warm_req |=> !reset_n && !flash_ready)
		else $error("warm not taken");
	ready_cause_a: assert property ($rose(flash_ready) |-> reset_n && $past(ready_busy_n))
		else $error("ready while busy");
	no_access_a: assert property (!select_n |-> flash_ready) else $error("select before ready");
	busy_flag_a: assert property (seq_busy == !flash_ready) else $error("busy flag wrong");
endmodule // flash_reset_host_asserts
bind flash_reset_host flash_reset_host_asserts #(.SUPPLY_CYC(SUPPLY_CYC), .RECOVER_CYC(RECOVER_CYC))
	chk_i (.clk(clk), .rst_b(rst_b), .supply_ok(supply_ok), .warm_req(warm_req),
	.hold_select(hold_select), .flash_ready(flash_ready), .seq_busy(seq_busy),
	.reset_n(reset_n), .select_n(select_n), .ready_busy_n(ready_busy_n));

// ---- dv/flash_pin_model.sv ----
// flash stand-in: only the busy pin reacts
// assumes the host clock paces its timers
`timescale 1ns/1ns
module flash_pin_model #(parameter int COLD = 40, parameter int WARM = 6) (
	// pins
	input wire logic clk,
	input wire logic reset_n,
	output logic ready_busy_n
);
	// cold load runs first and ignores every pin
	int busy = COLD;
	logic last = 1'b1;
	always @(posedge clk) begin
		last <= reset_n;
		if (busy > 0) busy <= busy - 1;
		else if (last && !reset_n) busy <= WARM;
	end
	assign ready_busy_n = (busy == 0);
endmodule // flash_pin_model

// ---- dv/test_flash_reset_host.sv ----
// self-checking bench for the reset sequencer
// assumes the pin model stands in for the flash
`timescale 1ns/1ns
module test_flash_reset_host;
	localparam int SUP = 20;
	localparam int REC = 10;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic supply_ok = 1'b0;
	logic warm_req = 1'b0;
	logic hold_select = 1'b0;
	logic flash_ready, seq_busy, reset_n, select_n, ready_busy_n;
	int failures = 0;
	int check_count = 0;
	int seed = 96;
	int cyc = 0;
	always #25 clk = ~clk;
	flash_reset_host #(.SUPPLY_CYC(SUP), .RECOVER_CYC(REC)) flash_reset_host_i (.clk(clk),
		.rst_b(rst_b), .supply_ok(supply_ok), .warm_req(warm_req), .hold_select(hold_select),
		.flash_ready(flash_ready), .seq_busy(seq_busy), .reset_n(reset_n), .select_n(select_n),
		.ready_busy_n(ready_busy_n));
	flash_pin_model flash_pin_model_i (.clk(clk), .reset_n(reset_n), .ready_busy_n(ready_busy_n));
	function automatic int min_low(bit cold);
		return cold ? SUP + REC - 1 : REC - 1;
	endfunction
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// counts reset-low samples until ready, bounded
	task automatic wait_ready(output int low);
		int t;
		t = 0;
		low = 0;
		while (flash_ready !== 1'b1 && t < 500) begin
			if (reset_n === 1'b0) low++;
			@(negedge clk);
			t++;
		end
		// a hang must count as a mismatch
		chk("ready reached", 1, flash_ready);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 4000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		int low;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		supply_ok = 1'b1;
		repeat (5) @(negedge clk);
		// a dropout must restart the setup count
		supply_ok = 1'b0;
		@(negedge clk);
		supply_ok = 1'b1;
		hold_select = 1'b1;
		wait_ready(low);
		chk("cold low", 1, low >= min_low(1));
		chk("cold busy", 1, ready_busy_n);
		$display("cold test done");
		repeat (4) begin
			repeat (20) begin
				hold_select = 1'($random(seed));
				repeat (2) @(negedge clk);
				chk("select", !hold_select, select_n);
			end
			warm_req = 1'b1;
			@(negedge clk);
			warm_req = 1'($random(seed));
			chk("warm pin", 0, reset_n);
			chk("warm select", 1, select_n);
			wait_ready(low);
			warm_req = 1'b0;
			chk("warm low", 1, low >= min_low(0));
			chk("warm busy", 1, ready_busy_n);
			$display("warm test done");
		end
		rst_b = 1'b0;
		@(negedge clk);
		chk("reset pin", 0, reset_n);
		chk("reset select", 1, select_n);
		rst_b = 1'b1;
		wait_ready(low);
		chk("rerun low", 1, low >= min_low(1));
		$display("rerun test done");
		finish_test();
	end
endmodule // test_flash_reset_host
